// File: csst_cfg.svh
// offsets, fuse codes, reset values and start-up counts for the clock start-up block
`ifndef CSST_CFG_SVH
`define CSST_CFG_SVH

// register byte offsets on the AHB-Lite slave (low address byte)
`define CSST_ADDR_TRIM 8'h00
`define CSST_ADDR_STATUS 8'h04
`define CSST_ADDR_CTRL 8'h08
`define CSST_CTRL_SLEEP_BIT 0
`define CSST_TRIM_WIDTH 8

// clock source select codes
`define CSST_CS_EXTCLK 4'h0
`define CSST_CS_INTRC_LO 4'h1
`define CSST_CS_INTRC_HI 4'h4
`define CSST_CS_EXTRC_LO 4'h5
`define CSST_CS_EXTRC_HI 4'h8
`define CSST_CS_LOWFREQ 4'h9

// start-up time select codes
`define CSST_SUT_00 2'h0
`define CSST_SUT_01 2'h1
`define CSST_SUT_10 2'h2
`define CSST_SUT_11 2'h3

// wake start-up counts, in cycles of the selected source
`define CSST_WAKE_6CK 17'h00006
`define CSST_WAKE_18CK 17'h00012
`define CSST_WAKE_1KCK 17'h00400

// short reset delay, in watchdog oscillator cycles
`define CSST_WDT_SHORT 17'h01000

// reset values
`define CSST_TRIM_RESET 8'h00
`define CSST_HRDATA_RESET 32'h0000_0000

`endif

// File: csst_pkg.sv
// types shared by the clock start-up and trim block
package csst_pkg;

  typedef enum {
    ST_RESET,
    ST_RSTDLY,
    ST_RUN,
    ST_SLEEP,
    ST_WAKE
  } csst_state_t;

  typedef enum logic [2:0] {
    SRC_EXTCLK,
    SRC_INTRC,
    SRC_EXTRC,
    SRC_LOWFREQ,
    SRC_CRYSTAL
  } csst_src_t;

  typedef enum logic [1:0] {
    DLY_NONE,
    DLY_SHORT,
    DLY_LONG
  } csst_dly_t;

endpackage

// File: csst_clock_ctrl.sv
// clock source selection, start-up delay sequencing and internal rc trim register
//
// What this block does
// - select code 1001 picks the low-frequency watch crystal as system clock
// - programmed oscillator option switches in 36 pF load caps, except internal rc
// - watch crystal: 00=1K+4.1ms, 01=1K+65ms, 10=32K+65ms, 11 reserved
// - codes 0101 to 1000 pick the external rc network, four frequency ranges
// - external rc: 18 clocks wake with none/4.1/65 ms; code 11 six clocks+4.1ms
// - codes 0001 to 0100 pick internal rc at 1, 2, 4, 8 MHz
// - internal rc: six clocks wake; none/4.1/65 ms reset delay; 11 reserved
// - every reset copies the factory 1 MHz calibration byte into the trim register
// - trim value raises oscillator frequency monotonically from 00 to ff
// - select code 0000 takes the system clock from the oscillator input pin
// - external clock: six clocks wake; none/4.1/65 ms reset delay; 11 reserved
// - watchdog oscillator always times the reset delay, whatever the source
// - wake from sleep counts start-up clocks on the source before running
// - reset delay counts 4096 or 65536 watchdog oscillator cycles
//
// Decided for this implementation: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/10ps
`include "csst_cfg.svh"

module csst_clock_ctrl
  import csst_pkg::*;
#(
  parameter logic [16:0] LF_LONG_CLOCKS = 17'h08000,
  parameter logic [16:0] WDT_LONG_CYCLES = 17'h10000
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [3:0] clockSourceSelect,
  input wire logic [1:0] startupTimeSelect,
  input wire logic oscillatorOption,
  input wire logic [7:0] factoryTrim,
  input wire logic srcClkPin,
  input wire logic wdtClkPin,
  input wire logic wakePin,
  output logic cpuRun,
  output csst_src_t sourceMode,
  output logic [1:0] rcRange,
  output logic capEnable,
  output logic configError,
  output logic [7:0] trimValue
);

  localparam int SW = 18;

  logic [SW-1:0] syncA;
  logic [SW-1:0] syncB;
  logic srcPrev;
  logic wdtPrev;
  logic wakePrev;
  logic srcEdge;
  logic wdtEdge;
  logic wakeEdge;
  logic [3:0] csLatched;
  logic [1:0] sutLatched;
  logic optLatched;
  csst_state_t state;
  csst_state_t next_state;
  logic [16:0] cnt;
  csst_src_t srcSel;
  csst_dly_t dlySel;
  logic [1:0] rangeSel;
  logic [16:0] wakeTarget;
  logic [16:0] delayTarget;
  logic badCfg;
  logic addrPhase;
  logic wrPend;
  logic [7:0] wrAddr;
  logic sleepCmd;
  logic [31:0] readWord;

  // pin side inputs pass two flops; stage A feeds stage B only
  always_ff @(posedge clk) begin
    if (clkEn) begin
      syncA <= {clockSourceSelect, startupTimeSelect, oscillatorOption, factoryTrim,
                srcClkPin, wdtClkPin, wakePin};
      syncB <= syncA;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      srcPrev <= 1'b0;
      wdtPrev <= 1'b0;
      wakePrev <= 1'b0;
    end else if (clkEn) begin
      srcPrev <= syncB[2];
      wdtPrev <= syncB[1];
      wakePrev <= syncB[0];
    end
  end

  assign srcEdge = clkEn & syncB[2] & ~srcPrev;
  assign wdtEdge = clkEn & syncB[1] & ~wdtPrev;
  assign wakeEdge = clkEn & syncB[0] & ~wakePrev;

  // fuses tracked only while reset is held, frozen afterwards
  always_ff @(posedge clk) begin
    if (rst) begin
      csLatched <= syncB[17:14];
      sutLatched <= syncB[13:12];
      optLatched <= syncB[11];
    end
  end

  // source and start-up decode; reserved codes fall back to the longest delay
  always_comb begin
    srcSel = SRC_CRYSTAL;
    rangeSel = 2'h0;
    wakeTarget = LF_LONG_CLOCKS;
    dlySel = DLY_LONG;
    badCfg = 1'b0;
    if (csLatched == `CSST_CS_EXTCLK) begin
      srcSel = SRC_EXTCLK;
      wakeTarget = `CSST_WAKE_6CK;
      badCfg = (sutLatched == `CSST_SUT_11);
      if (sutLatched == `CSST_SUT_00) begin
        dlySel = DLY_NONE;
      end else if (sutLatched == `CSST_SUT_01) begin
        dlySel = DLY_SHORT;
      end
    end else if (csLatched <= `CSST_CS_INTRC_HI) begin
      srcSel = SRC_INTRC;
      rangeSel = 2'(csLatched - `CSST_CS_INTRC_LO);
      wakeTarget = `CSST_WAKE_6CK;
      badCfg = (sutLatched == `CSST_SUT_11) | ~optLatched;
      if (sutLatched == `CSST_SUT_00) begin
        dlySel = DLY_NONE;
      end else if (sutLatched == `CSST_SUT_01) begin
        dlySel = DLY_SHORT;
      end
    end else if (csLatched <= `CSST_CS_EXTRC_HI) begin
      srcSel = SRC_EXTRC;
      rangeSel = 2'(csLatched - `CSST_CS_EXTRC_LO);
      if (sutLatched == `CSST_SUT_11) begin
        wakeTarget = `CSST_WAKE_6CK;
        dlySel = DLY_SHORT;
      end else begin
        wakeTarget = `CSST_WAKE_18CK;
        if (sutLatched == `CSST_SUT_00) begin
          dlySel = DLY_NONE;
        end else if (sutLatched == `CSST_SUT_01) begin
          dlySel = DLY_SHORT;
        end
      end
    end else if (csLatched == `CSST_CS_LOWFREQ) begin
      srcSel = SRC_LOWFREQ;
      badCfg = (sutLatched == `CSST_SUT_11);
      if (sutLatched == `CSST_SUT_00) begin
        wakeTarget = `CSST_WAKE_1KCK;
        dlySel = DLY_SHORT;
      end else if (sutLatched == `CSST_SUT_01) begin
        wakeTarget = `CSST_WAKE_1KCK;
      end
    end else begin
      // full-swing crystal modes are not handled here
      badCfg = 1'b1;
    end
  end

  assign delayTarget = (dlySel == DLY_SHORT) ? `CSST_WDT_SHORT : WDT_LONG_CYCLES;

  always_comb begin
    next_state = state;
    case (state)
      ST_RESET: begin
        next_state = (dlySel == DLY_NONE) ? ST_RUN : ST_RSTDLY;
      end
      ST_RSTDLY: begin
        if (cnt == delayTarget) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (sleepCmd) begin
          next_state = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wakeEdge) begin
          next_state = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (cnt == wakeTarget) begin
          next_state = ST_RUN;
        end
      end
      default: begin
        next_state = ST_RESET;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ST_RESET;
      cpuRun <= 1'b0;
    end else if (clkEn) begin
      state <= next_state;
      cpuRun <= (next_state == ST_RUN);
    end
  end

  // one counter serves both delays; it restarts on every state change
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt <= 17'h00000;
    end else if (clkEn) begin
      if (state != next_state) begin
        cnt <= 17'h00000;
      end else if (state == ST_RSTDLY && wdtEdge && cnt != delayTarget) begin
        cnt <= cnt + 17'h00001;
      end else if (state == ST_WAKE && srcEdge && cnt != wakeTarget) begin
        cnt <= cnt + 17'h00001;
      end
    end
  end

  // decoded controls toward the oscillator pads
  always_ff @(posedge clk) begin
    if (rst) begin
      sourceMode <= SRC_INTRC;
      rcRange <= 2'h0;
      capEnable <= 1'b0;
      configError <= 1'b0;
    end else if (clkEn) begin
      sourceMode <= srcSel;
      rcRange <= rangeSel;
      capEnable <= ~optLatched & (srcSel != SRC_INTRC);
      configError <= badCfg;
    end
  end

  // bus slave: zero wait states, always OKAY
  assign addrPhase = hsel & hready & htrans[1];

  always_comb begin
    readWord = 32'h0000_0000;
    if (haddr[7:0] == `CSST_ADDR_TRIM) begin
      readWord = {24'h00_0000, trimValue};
    end else if (haddr[7:0] == `CSST_ADDR_STATUS) begin
      readWord = {20'h0_0000, cpuRun, sourceMode, configError, optLatched, sutLatched, csLatched};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= `CSST_HRDATA_RESET;
      wrPend <= 1'b0;
      wrAddr <= 8'h00;
    end else if (clkEn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wrPend <= addrPhase & hwrite;
      if (addrPhase) begin
        wrAddr <= haddr[7:0];
        if (!hwrite) begin
          hrdata <= readWord;
        end
      end
    end
  end

  // trim: factory byte while reset is held, then software owned
  always_ff @(posedge clk) begin
    if (rst) begin
      trimValue <= syncB[10:3];
    end else if (clkEn && wrPend && wrAddr == `CSST_ADDR_TRIM) begin
      trimValue <= hwdata[`CSST_TRIM_WIDTH-1:0];
    end
  end

  // sleep request is a one-cycle pulse; ignored outside run
  always_ff @(posedge clk) begin
    if (rst) begin
      sleepCmd <= 1'b0;
    end else if (clkEn) begin
      sleepCmd <= wrPend && wrAddr == `CSST_ADDR_CTRL && hwdata[`CSST_CTRL_SLEEP_BIT];
    end
  end

  property p_lowfreq_sel;
    @(posedge clk) disable iff (rst)
    !rst && clkEn && csLatched == `CSST_CS_LOWFREQ |=> sourceMode == SRC_LOWFREQ;
  endproperty
  a_lowfreq_sel: assert property (p_lowfreq_sel) else $error("low-frequency source not selected");

  property p_cap_intrc;
    @(posedge clk) disable iff (rst)
    capEnable |-> sourceMode != SRC_INTRC && !optLatched;
  endproperty
  a_cap_intrc: assert property (p_cap_intrc) else $error("load caps on with internal rc");

  property p_lf_long_wake;
    @(posedge clk) disable iff (rst)
    state == ST_WAKE && next_state == ST_RUN && srcSel == SRC_LOWFREQ && sutLatched == `CSST_SUT_10
      |-> cnt == LF_LONG_CLOCKS;
  endproperty
  a_lf_long_wake: assert property (p_lf_long_wake) else $error("watch crystal wake count wrong");

  property p_extrc_range;
    @(posedge clk) disable iff (rst)
    csLatched == `CSST_CS_EXTRC_HI |-> srcSel == SRC_EXTRC && rangeSel == 2'h3;
  endproperty
  a_extrc_range: assert property (p_extrc_range) else $error("external rc range wrong");

  property p_extrc_wake;
    @(posedge clk) disable iff (rst)
    srcSel == SRC_EXTRC |-> wakeTarget == ((sutLatched == `CSST_SUT_11) ? `CSST_WAKE_6CK : `CSST_WAKE_18CK);
  endproperty
  a_extrc_wake: assert property (p_extrc_wake) else $error("external rc wake count wrong");

  property p_intrc_sel;
    @(posedge clk) disable iff (rst)
    csLatched == `CSST_CS_INTRC_HI |-> srcSel == SRC_INTRC && rangeSel == 2'h3;
  endproperty
  a_intrc_sel: assert property (p_intrc_sel) else $error("internal rc code decoded wrong");

  property p_intrc_nodelay;
    @(posedge clk) disable iff (rst)
    !rst && state == ST_RESET && clkEn && srcSel == SRC_INTRC && sutLatched == `CSST_SUT_00 |=> cpuRun;
  endproperty
  a_intrc_nodelay: assert property (p_intrc_nodelay) else $error("internal rc run not immediate");

  property p_trim_load;
    @(posedge clk)
    rst ##1 !rst |-> trimValue == $past(syncB[10:3]);
  endproperty
  a_trim_load: assert property (p_trim_load) else $error("factory trim not loaded");

  property p_trim_write;
    @(posedge clk) disable iff (rst)
    clkEn && wrPend && wrAddr == `CSST_ADDR_TRIM ##1 clkEn && addrPhase && !hwrite && haddr[7:0] == `CSST_ADDR_TRIM
      |=> hrdata[7:0] == $past(hwdata[7:0], 2);
  endproperty
  a_trim_write: assert property (p_trim_write) else $error("trim readback wrong");

  property p_extclk_sel;
    @(posedge clk) disable iff (rst)
    csLatched == `CSST_CS_EXTCLK |-> srcSel == SRC_EXTCLK && wakeTarget == `CSST_WAKE_6CK;
  endproperty
  a_extclk_sel: assert property (p_extclk_sel) else $error("external clock decode wrong");

  property p_wdt_only;
    @(posedge clk) disable iff (rst)
    state == ST_RSTDLY && !wdtEdge && state == next_state |=> $stable(cnt);
  endproperty
  a_wdt_only: assert property (p_wdt_only) else $error("reset delay counted off watchdog");

  property p_wake_gate;
    @(posedge clk) disable iff (rst)
    state == ST_WAKE && cnt != wakeTarget |=> !cpuRun;
  endproperty
  a_wake_gate: assert property (p_wake_gate) else $error("ran before start-up count");

  property p_rst_delay;
    @(posedge clk) disable iff (rst)
    state == ST_RSTDLY && next_state == ST_RUN |-> cnt == delayTarget && delayTarget >= `CSST_WDT_SHORT;
  endproperty
  a_rst_delay: assert property (p_rst_delay) else $error("reset delay length wrong");

  property p_fuse_hold;
    @(posedge clk) disable iff (rst)
    !$past(rst) |-> $stable(csLatched) && $stable(sutLatched) && $stable(optLatched);
  endproperty
  a_fuse_hold: assert property (p_fuse_hold) else $error("fuse bits changed in operation");

endmodule

// File: csst_osc_model.sv
// source oscillator and watchdog oscillator on the far side of the start-up block
`timescale 1ns/10ps

module csst_osc_model #(
  parameter int SRC_HALF = 81,
  parameter int WDT_HALF = 77
) (
  output logic srcClk,
  output logic wdtClk
);
  initial begin
    srcClk = 1'b0;
    wdtClk = 1'b0;
  end

  // steady period, no jump between cycles, so no reset is owed
  always #(SRC_HALF) srcClk = ~srcClk;

  // separate oscillator, off-grid from both clk and the source
  always #(WDT_HALF) wdtClk = ~wdtClk;
endmodule

// File: csst_clock_ctrl_bench.sv
// self-checking bench for the clock start-up and trim block
`timescale 1ns/10ps
`include "csst_cfg.svh"

module csst_clock_ctrl_bench import csst_pkg::*;;
  localparam logic Y = 1'b1;
  localparam logic N = 1'b0;
  typedef struct packed {
    logic [3:0] cs;
    logic [1:0] startup_time_select;
    logic opt;
    csst_src_t mode;
    logic [1:0] rng;
    logic cap, err, run, rc;
  } csst_row_t;
  // run is sampled three edges after release, long before any reset delay ends
  csst_row_t rows [16] = '{
    '{4'h0, 2'h0, Y, SRC_EXTCLK, 2'h0, N, N, Y, N},
    '{4'h0, 2'h0, N, SRC_EXTCLK, 2'h0, Y, N, Y, N},
    '{4'h0, 2'h3, Y, SRC_EXTCLK, 2'h0, N, Y, N, N},
    '{4'h1, 2'h0, Y, SRC_INTRC, 2'h0, N, N, Y, Y},
    '{4'h2, 2'h0, Y, SRC_INTRC, 2'h1, N, N, Y, Y},
    '{4'h3, 2'h0, Y, SRC_INTRC, 2'h2, N, N, Y, Y},
    '{4'h4, 2'h0, N, SRC_INTRC, 2'h3, N, Y, Y, Y},
    '{4'h1, 2'h3, Y, SRC_INTRC, 2'h0, N, Y, N, Y},
    '{4'h5, 2'h0, Y, SRC_EXTRC, 2'h0, N, N, Y, Y},
    '{4'h6, 2'h0, N, SRC_EXTRC, 2'h1, Y, N, Y, Y},
    '{4'h7, 2'h1, Y, SRC_EXTRC, 2'h2, N, N, N, Y},
    '{4'h8, 2'h0, Y, SRC_EXTRC, 2'h3, N, N, Y, Y},
    '{4'h5, 2'h3, Y, SRC_EXTRC, 2'h0, N, N, N, Y},
    '{4'h9, 2'h0, N, SRC_LOWFREQ, 2'h0, Y, N, N, N},
    '{4'h9, 2'h3, Y, SRC_LOWFREQ, 2'h0, N, Y, N, N},
    '{4'ha, 2'h0, Y, SRC_CRYSTAL, 2'h0, N, Y, N, N}
  };
  logic clk, rst, clkEn, hsel, hwrite, hready, hreadyout, hresp, wakePin, opt;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0] htrans, startup_time_select, rcRange;
  logic [2:0] hsize;
  logic [3:0] cs;
  logic [7:0] facTrim, trimValue;
  logic srcClkPin, wdtClkPin, cpuRun, capEnable, configError;
  csst_src_t sourceMode;
  int errorCnt = 0;
  int checkCount = 0;

  assign hready = hreadyout;

  csst_clock_ctrl #(.LF_LONG_CLOCKS(17'h00028), .WDT_LONG_CYCLES(17'h01388)) dut (
    .clk(clk), .rst(rst), .clkEn(clkEn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .clockSourceSelect(cs), .startupTimeSelect(startup_time_select),
    .oscillatorOption(opt), .factoryTrim(facTrim), .srcClkPin(srcClkPin), .wdtClkPin(wdtClkPin),
    .wakePin(wakePin), .cpuRun(cpuRun), .sourceMode(sourceMode), .rcRange(rcRange),
    .capEnable(capEnable), .configError(configError), .trimValue(trimValue)
  );

  csst_osc_model osc (.srcClk(srcClkPin), .wdtClk(wdtClkPin));

  always #12.5 clk = ~clk;

  task automatic end_of_test;
    if (errorCnt == 0 && checkCount > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checkCount++;
    if (g !== e) begin
      errorCnt++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask

  // entered right after a rising edge; holds each phase until hready is seen
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'h0, 32'(hresp));
  endtask

  // five edges so the two sync flops carry the new fuses before release
  task automatic rst_dut(input logic [3:0] c, input logic [1:0] s, input logic o);
    @(posedge clk);
    rst <= 1'b1;
    cs <= c;
    startup_time_select <= s;
    opt <= o;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
  endtask

  task automatic wait_run(input int lim);
    int k;
    k = 0;
    while (cpuRun !== 1'b1 && k < lim) begin
      @(posedge clk);
      k++;
    end
    chk("run late", 32'h1, 32'(cpuRun));
  endtask

  task automatic wake_test(input int n);
    ahb(1'b1, `CSST_ADDR_CTRL, 32'h1, d);
    repeat (4) @(posedge clk);
    #1 chk("sleep run", 32'h0, 32'(cpuRun));
    @(posedge clk);
    wakePin <= 1'b1;
    repeat (n - 2) @(posedge srcClkPin);
    #1 chk("wake early", 32'h0, 32'(cpuRun));
    wait_run(60);
    wakePin <= 1'b0;
  endtask

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    clkEn = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    cs = 4'h1;
    startup_time_select = 2'h2;
    opt = 1'b1;
    facTrim = 8'h5a;
    wakePin = 1'b0;
    foreach (rows[i]) begin
      rst_dut(rows[i].cs, rows[i].startup_time_select, rows[i].opt);
      repeat (3) @(posedge clk);
      #1 chk("mode", 32'(rows[i].mode), 32'(sourceMode));
      chk("cap", 32'(rows[i].cap), 32'(capEnable));
      chk("cfgerr", 32'(rows[i].err), 32'(configError));
      chk("run", 32'(rows[i].run), 32'(cpuRun));
      if (rows[i].rc)
        chk("range", 32'(rows[i].rng), 32'(rcRange));
    end
    rst_dut(4'h2, 2'h0, Y);
    repeat (3) @(posedge clk);
    #1 chk("trim rst", 32'h5a, 32'(trimValue));
    @(posedge clk);
    ahb(1'b0, `CSST_ADDR_STATUS, 32'h0, d);
    chk("status", {20'h0, Y, SRC_INTRC, N, Y, 2'h0, 4'h2}, d);
    ahb(1'b1, `CSST_ADDR_TRIM, 32'h0000_00c3, d);
    ahb(1'b0, `CSST_ADDR_TRIM, 32'h0, d);
    chk("trim rd", 32'h0000_00c3, d);
    chk("trim out", 32'h0000_00c3, 32'(trimValue));
    ahb(1'b1, 8'h0c, 32'hffff_ffff, d);
    ahb(1'b0, 8'h0c, 32'h0, d);
    chk("unmapped", 32'h0, d);
    cs <= 4'h9;
    opt <= N;
    facTrim <= 8'ha5;
    repeat (6) @(posedge clk);
    #1 chk("fuse hold", 32'(SRC_INTRC), 32'(sourceMode));
    chk("trim hold", 32'h0000_00c3, 32'(trimValue));
    @(posedge clk);
    // frozen slave must drop the write
    clkEn <= 1'b0;
    ahb(1'b1, `CSST_ADDR_TRIM, 32'h0000_003c, d);
    clkEn <= 1'b1;
    #1 chk("trim frozen", 32'h0000_00c3, 32'(trimValue));
    @(posedge clk);
    wake_test(6);
    rst_dut(4'h2, 2'h0, Y);
    repeat (3) @(posedge clk);
    #1 chk("trim reload", 32'ha5, 32'(trimValue));
    rst_dut(4'h5, 2'h0, Y);
    repeat (3) @(posedge clk);
    wake_test(18);
    rst_dut(4'h1, 2'h1, Y);
    repeat (4000) @(posedge wdtClkPin);
    #1 chk("dly run", 32'h0, 32'(cpuRun));
    @(posedge clk);
    wait_run(1500);
    rst_dut(4'h9, 2'h2, Y);
    wait_run(32000);
    @(posedge clk);
    wake_test(40);
    end_of_test;
  end

  // whole run is near 57000 cycles
  initial begin
    #(80000 * 25);
    errorCnt++;
    end_of_test;
  end
endmodule
